// ==== hdl/ievm_pkg.sv ====
// package: offsets, fields, reset values and carriers of the invalidation event registers
package ievm_pkg;
	// ===============================================
	// register offsets (byte addresses)
	localparam logic [11:0] OFS_WAIT_STATUS = 12'h09c;
	localparam logic [11:0] OFS_EVENT_CTRL = 12'h0a0;
	localparam logic [11:0] OFS_MSG_DATA = 12'h0a4;
	localparam logic [11:0] OFS_ADDR_LOW = 12'h0a8;
	localparam logic [11:0] OFS_ADDR_HIGH = 12'h0ac;
	localparam logic [11:0] OFS_TABLE_LO = 12'h0b8;
	localparam logic [11:0] OFS_TABLE_HI = 12'h0bc;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h0c0;
	localparam logic [11:0] OFS_IRQ_CLEAR = 12'h0c4;
	localparam logic [11:0] OFS_IRQ_ENABLE = 12'h0c8;
	// ===============================================
	// field positions
	localparam int MASK_BIT = 31;
	localparam int PENDING_BIT = 30;
	localparam int WIDE_EN_BIT = 11;
	localparam int IRQ_W = 2;
	localparam int IRQ_WAIT = 0;
	localparam int IRQ_SENT = 1;
	// ===============================================
	// reset values and constants
	localparam logic MASK_RST = 1'b1;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [3:0] SIZE_RST = 4'h0;
	localparam logic [51:0] BASE_RST = 52'h0_0000_0000_0000;
	localparam logic [31:0] DEST_NARROW = 32'h0000_ff00;
	localparam logic [31:0] DEST_WIDE = 32'hffff_ffff;
	localparam logic [16:0] ENTRIES_ONE = 17'h0_0001;
	localparam logic [16:0] ENTRIES_RST = 17'h0_0002;
	// ===============================================
	// carriers
	typedef struct packed {
		logic qi;        // queued_invalidation_support
		logic wide_interrupt_support;       // wide_interrupt_support
		logic ir;        // interrupt_remap_support
		logic wide_data; // 32-bit message data support
	} ievm_cap_s;
	typedef struct packed {
		logic [63:0] addr;
		logic [31:0] data;
	} ievm_msg_s;
	typedef struct packed {
		logic [51:0] base;      // table_base_field, address bits 63:12
		logic [3:0] size;
		logic wide_en;          // wide_destination_enable
		logic [31:0] dest_mask; // destination identifier bits in use
		logic [16:0] entries;
	} ievm_table_s;
	typedef enum logic [1:0] {
		MS_IDLE = 2'b00,
		MS_SEND = 2'b01
	} ievm_state_e;
endpackage : ievm_pkg

// ==== hdl/ievm_regs.sv ====
// module: invalidation event message and remap table registers behind apb
// ===============================================
// Notes on behaviour
// - without queued invalidation, data and low address read zero, writes ignored.
// - data bits 15:0 read-write, reset zero, sent as message payload.
// - data bits 31:16 live only with 32-bit data support, else zero.
// - low address keeps bits 31:2; bits 1:0 read zero.
// - with both supports, upper address is full 32-bit read-write, reset zero.
// - lacking either support, upper address reads zero and ignores writes.
// - without interrupt remapping, the 64-bit table register reads zero.
// - table base bits 63:12, 4 KB aligned, reset zero.
// - base bits above host address width may be left out.
// - base field reads back exactly the last value written.
// - wide enable 0 uses destination bits 15:8 only.
// - wide enable 1 uses all 32 destination bits.
// - without wide interrupt support the wide enable bit reads zero.
// - table entries are two to the power of size plus one.
// - no completion message while the mask bit is set; mask resets to 1.
// - pending set on flagged wait completion, kept while message held unless wait status is cleared.
`timescale 1ns/1ps
`default_nettype none
module ievm_regs (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ievm_pkg::ievm_cap_s cap,
	input wire logic wait_done,
	output ievm_pkg::ievm_msg_s msg,
	output logic msg_valid,
	input wire logic msg_ready,
	output ievm_pkg::ievm_table_s tcfg,
	output logic irq
);
	// ===============================================
	// storage
	logic [31:0] data_q;
	logic [31:2] addr_low;
	logic [31:0] addr_high;
	logic mask;
	logic pending;
	logic wait_status;
	logic [ievm_pkg::IRQ_W-1:0] irq_status;
	logic [ievm_pkg::IRQ_W-1:0] irq_enable;
	ievm_pkg::ievm_state_e state;
	ievm_pkg::ievm_state_e next_state;
	logic next_mask;
	logic next_pending;
	logic next_wait_status;
	logic [ievm_pkg::IRQ_W-1:0] next_irq_status;
	logic [ievm_pkg::IRQ_W-1:0] irq_event;
	logic wr_acc;
	logic rd_setup;
	logic [31:0] rd_mux;
	logic rd_hit;
	logic ws_clr;
	logic new_evt;
	logic fire;
	logic hi_ok;

	// ===============================================
	// apb decode
	// a write takes effect on the edge that samples pready high
	assign wr_acc = psel & penable & pready & pwrite;
	assign rd_setup = psel & penable & ~pready;
	assign hi_ok = cap.qi & cap.wide_interrupt_support;

	// one wait state, then the answer with data and error flag
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			prdata <= ievm_pkg::WORD_RST;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= rd_setup;
			if (rd_setup) begin
				prdata <= pwrite ? ievm_pkg::WORD_RST : rd_mux;
				pslverr <= ~rd_hit;
			end
		end
	end

	// read view, gated by the capability straps
	always_comb begin
		rd_mux = ievm_pkg::WORD_RST;
		rd_hit = 1'b1;
		case (paddr)
			ievm_pkg::OFS_WAIT_STATUS: begin
				rd_mux[0] = wait_status & cap.qi;
			end
			ievm_pkg::OFS_EVENT_CTRL: begin
				rd_mux[ievm_pkg::MASK_BIT] = mask & cap.qi;
				rd_mux[ievm_pkg::PENDING_BIT] = pending & cap.qi;
			end
			ievm_pkg::OFS_MSG_DATA: begin
				rd_mux = cap.qi ? data_q : ievm_pkg::WORD_RST;
			end
			ievm_pkg::OFS_ADDR_LOW: begin
				rd_mux = cap.qi ? {addr_low, 2'b00} : ievm_pkg::WORD_RST;
			end
			ievm_pkg::OFS_ADDR_HIGH: begin
				rd_mux = hi_ok ? addr_high : ievm_pkg::WORD_RST;
			end
			ievm_pkg::OFS_TABLE_LO: begin
				if (cap.ir) begin
					rd_mux = {tcfg.base[19:0], tcfg.wide_en, 7'h00, tcfg.size};
				end
			end
			ievm_pkg::OFS_TABLE_HI: begin
				rd_mux = cap.ir ? tcfg.base[51:20] : ievm_pkg::WORD_RST;
			end
			ievm_pkg::OFS_IRQ_STATUS: begin
				rd_mux[ievm_pkg::IRQ_W-1:0] = irq_status;
			end
			ievm_pkg::OFS_IRQ_CLEAR: begin
				rd_mux = ievm_pkg::WORD_RST;
			end
			ievm_pkg::OFS_IRQ_ENABLE: begin
				rd_mux[ievm_pkg::IRQ_W-1:0] = irq_enable;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// ===============================================
	// message data and address registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			data_q <= ievm_pkg::WORD_RST;
			addr_low <= ievm_pkg::WORD_RST[31:2];
			addr_high <= ievm_pkg::WORD_RST;
		end else if (ce && wr_acc) begin
			if (paddr == ievm_pkg::OFS_MSG_DATA && cap.qi) begin
				data_q[15:0] <= pwdata[15:0];
				data_q[31:16] <= cap.wide_data ? pwdata[31:16] : 16'h0000;
			end
			if (paddr == ievm_pkg::OFS_ADDR_LOW && cap.qi) begin
				addr_low <= pwdata[31:2];
			end
			if (paddr == ievm_pkg::OFS_ADDR_HIGH && hi_ok) begin
				addr_high <= pwdata;
			end
		end
	end

	// ===============================================
	// remap table configuration, all base bits kept
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tcfg.base <= ievm_pkg::BASE_RST;
			tcfg.size <= ievm_pkg::SIZE_RST;
			tcfg.wide_en <= 1'b0;
			tcfg.dest_mask <= ievm_pkg::DEST_NARROW;
			tcfg.entries <= ievm_pkg::ENTRIES_RST;
		end else if (ce && wr_acc && cap.ir) begin
			if (paddr == ievm_pkg::OFS_TABLE_LO) begin
				tcfg.base[19:0] <= pwdata[31:12];
				tcfg.size <= pwdata[3:0];
				tcfg.entries <= ievm_pkg::ENTRIES_ONE << (5'(pwdata[3:0]) + 5'd1);
				tcfg.wide_en <= cap.wide_interrupt_support & pwdata[ievm_pkg::WIDE_EN_BIT];
				tcfg.dest_mask <= (cap.wide_interrupt_support & pwdata[ievm_pkg::WIDE_EN_BIT]) ?
					ievm_pkg::DEST_WIDE : ievm_pkg::DEST_NARROW;
			end
			if (paddr == ievm_pkg::OFS_TABLE_HI) begin
				tcfg.base[51:20] <= pwdata;
			end
		end
	end

	// ===============================================
	// completion event, mask and pending
	assign ws_clr = wr_acc & (paddr == ievm_pkg::OFS_WAIT_STATUS) & pwdata[0] & cap.qi;
	assign new_evt = wait_done & cap.qi & ~wait_status;
	assign fire = (state == ievm_pkg::MS_SEND) & msg_ready;

	// next values; a completion beats a clear in the same cycle
	always_comb begin
		next_wait_status = wait_status;
		if (ws_clr) begin
			next_wait_status = 1'b0;
		end
		if (wait_done && cap.qi) begin
			next_wait_status = 1'b1;
		end
		next_mask = mask;
		if (wr_acc && paddr == ievm_pkg::OFS_EVENT_CTRL && cap.qi) begin
			next_mask = pwdata[ievm_pkg::MASK_BIT];
		end
		next_pending = pending;
		if (fire || ws_clr) begin
			next_pending = 1'b0;
		end
		if (new_evt) begin
			next_pending = 1'b1;
		end
		next_state = (next_pending && !next_mask && !fire) ?
			ievm_pkg::MS_SEND : ievm_pkg::MS_IDLE;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wait_status <= 1'b0;
			mask <= ievm_pkg::MASK_RST;
			pending <= 1'b0;
		end else if (ce) begin
			wait_status <= next_wait_status;
			mask <= next_mask;
			pending <= next_pending;
		end
	end

	// ===============================================
	// message issue: payload latched on entry to send
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= ievm_pkg::MS_IDLE;
			msg_valid <= 1'b0;
			msg <= '0;
		end else if (ce) begin
			state <= next_state;
			msg_valid <= (next_state == ievm_pkg::MS_SEND);
			case (state)
				ievm_pkg::MS_IDLE: begin
					if (next_state == ievm_pkg::MS_SEND) begin
						msg.addr <= {addr_high, addr_low, 2'b00};
						msg.data <= data_q;
					end
				end
				ievm_pkg::MS_SEND: begin
					msg <= msg;
				end
				default: begin
					msg <= msg;
				end
			endcase
		end
	end

	// ===============================================
	// interrupt status, enable, clear
	assign irq_event[ievm_pkg::IRQ_WAIT] = new_evt;
	assign irq_event[ievm_pkg::IRQ_SENT] = fire;

	genvar gi;
	generate
		for (gi = 0; gi < ievm_pkg::IRQ_W; gi++) begin : g_irq
			// sticky bit, set wins over a clear in the same cycle
			assign next_irq_status[gi] = irq_event[gi] |
				(irq_status[gi] & ~(wr_acc & (paddr == ievm_pkg::OFS_IRQ_CLEAR) & pwdata[gi]));
		end
	endgenerate

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_status <= '0;
			irq_enable <= '0;
			irq <= 1'b0;
		end else if (ce) begin
			irq_status <= next_irq_status;
			if (wr_acc && paddr == ievm_pkg::OFS_IRQ_ENABLE) begin
				irq_enable <= pwdata[ievm_pkg::IRQ_W-1:0];
				irq <= |(next_irq_status & pwdata[ievm_pkg::IRQ_W-1:0]);
			end else begin
				irq <= |(next_irq_status & irq_enable);
			end
		end
	end

	// ===============================================
	// assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	property p_mask_blocks;
		mask |-> !msg_valid;
	endproperty
	a_mask_blocks: assert property (p_mask_blocks) else $error("message while masked");

	property p_pending_set;
		ce && wait_done && cap.qi && !wait_status |=> pending;
	endproperty
	a_pending_set: assert property (p_pending_set) else $error("pending not set");

	property p_pending_held;
		pending && mask && ce && !ws_clr |=> pending;
	endproperty
	a_pending_held: assert property (p_pending_held) else $error("pending lost");

	property p_payload;
		$rose(msg_valid) |-> msg.addr == {$past(addr_high), $past(addr_low), 2'b00}
			&& msg.data == $past(data_q);
	endproperty
	a_payload: assert property (p_payload) else $error("bad message payload");

	property p_qi_off;
		!cap.qi && rd_setup && ce && !pwrite
			&& (paddr == ievm_pkg::OFS_MSG_DATA || paddr == ievm_pkg::OFS_ADDR_LOW)
			|=> prdata == ievm_pkg::WORD_RST;
	endproperty
	a_qi_off: assert property (p_qi_off) else $error("data or address not zero");

	property p_low_bits;
		rd_setup && ce && !pwrite && paddr == ievm_pkg::OFS_ADDR_LOW |=> prdata[1:0] == 2'b00;
	endproperty
	a_low_bits: assert property (p_low_bits) else $error("address low bits set");

	property p_ir_off;
		!cap.ir && rd_setup && ce && !pwrite && paddr[11:3] == ievm_pkg::OFS_TABLE_LO[11:3]
			|=> prdata == ievm_pkg::WORD_RST;
	endproperty
	a_ir_off: assert property (p_ir_off) else $error("table register not zero");

	property p_rsvd;
		rd_setup && ce && !pwrite && paddr == ievm_pkg::OFS_TABLE_LO |=> prdata[10:4] == 7'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved table bits set");

	property p_dest;
		tcfg.dest_mask == (tcfg.wide_en ? ievm_pkg::DEST_WIDE : ievm_pkg::DEST_NARROW);
	endproperty
	a_dest: assert property (p_dest) else $error("destination mask wrong");

	property p_entries;
		tcfg.entries == (ievm_pkg::ENTRIES_ONE << (5'(tcfg.size) + 5'd1));
	endproperty
	a_entries: assert property (p_entries) else $error("entry count wrong");

	property p_wide_off;
		!cap.wide_interrupt_support |-> !tcfg.wide_en;
	endproperty
	a_wide_off: assert property (p_wide_off) else $error("wide enable without support");

	property p_base_back;
		ce && cap.ir && wr_acc && paddr == ievm_pkg::OFS_TABLE_HI |=> tcfg.base[51:20] == $past(pwdata);
	endproperty
	a_base_back: assert property (p_base_back) else $error("base not stored");

	property p_hi_data;
		!cap.wide_data |-> data_q[31:16] == 16'h0000;
	endproperty
	a_hi_data: assert property (p_hi_data) else $error("upper data without support");

	c_send: cover property (msg_valid && msg_ready);
	c_masked: cover property (pending && mask ##1 !mask ##[1:4] msg_valid);
	c_irq: cover property ($rose(irq));
	c_err: cover property (pready && pslverr);
endmodule : ievm_regs
`default_nettype wire

// ==== tb/ievm_regs_test.sv ====
// testbench: apb register checks and completion message sequence of the event registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); err_total++; end end
module ievm_regs_test;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	ievm_pkg::ievm_cap_s cap = 4'hf;
	logic wait_done = 1'b0;
	ievm_pkg::ievm_msg_s msg;
	logic msg_valid;
	logic msg_ready = 1'b0;
	logic ce = 1'b1;
	ievm_pkg::ievm_table_s tcfg;
	logic irq;
	int err_total = 0;
	int total_checks = 0;
	logic [31:0] rdv;
	logic errv;
	logic [11:0] offs [5] = '{12'h0a4, 12'h0a8, 12'h0ac, 12'h0b8, 12'h0bc};
	logic [3:0] caps [3] = '{4'hf, 4'ha, 4'h0};
	// ===============================================
	// clock and device under test
	always #2 clk = ~clk;
	ievm_regs dut (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cap(cap), .wait_done(wait_done), .msg(msg),
		.msg_valid(msg_valid), .msg_ready(msg_ready), .tcfg(tcfg), .irq(irq));
	// ===============================================
	// verdict and end of run
	task automatic tally_and_finish();
		if (err_total == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// one apb transfer: setup, access until pready sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			err_total++;
			tally_and_finish();
		end
	endtask : apb
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK("read data", e, rdv)
		`CHK("read error", 1'b0, errv)
	endtask : rd_chk
	// reset with the given capability straps, held 20 cycles
	task automatic do_reset(input logic [3:0] c);
		@(posedge clk);
		rstn <= 1'b0;
		cap <= c;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
	endtask : do_reset
	// expected readback after writing all ones, per capability set
	function automatic logic [31:0] ones_exp(input int i, input logic [3:0] c);
		case (i)
			0: ones_exp = c[3] ? (c[0] ? 32'hffff_ffff : 32'h0000_ffff) : 32'h0000_0000;
			1: ones_exp = c[3] ? 32'hffff_fffc : 32'h0000_0000;
			2: ones_exp = (c[3] & c[2]) ? 32'hffff_ffff : 32'h0000_0000;
			3: ones_exp = c[1] ? (c[2] ? 32'hffff_f80f : 32'hffff_f00f) : 32'h0000_0000;
			default: ones_exp = c[1] ? 32'hffff_ffff : 32'h0000_0000;
		endcase
	endfunction : ones_exp
	// ===============================================
	// main sequence
	initial begin
		int n;
		do_reset(4'hf);
		rd_chk(12'h0a0, 32'h8000_0000);
		`CHK("entries reset", 17'h0_0002, tcfg.entries)
		`CHK("dest reset", 32'h0000_ff00, tcfg.dest_mask)
		// table register: both words, wide destinations, largest size
		apb(1'b1, 12'h0b8, 32'hffff_ffff);
		apb(1'b1, 12'h0bc, 32'h1234_5678);
		rd_chk(12'h0b8, 32'hffff_f80f);
		rd_chk(12'h0bc, 32'h1234_5678);
		repeat (2) @(posedge clk);
		`CHK("base", {32'h1234_5678, 20'hf_ffff}, tcfg.base)
		`CHK("entries max", 17'h1_0000, tcfg.entries)
		`CHK("dest wide", 32'hffff_ffff, tcfg.dest_mask)
		apb(1'b1, 12'h0b8, 32'h0000_5003);
		rd_chk(12'h0b8, 32'h0000_5003);
		repeat (2) @(posedge clk);
		`CHK("entries 3", 17'h0_0010, tcfg.entries)
		`CHK("dest narrow", 32'h0000_ff00, tcfg.dest_mask)
		apb(1'b0, 12'h0f0, 32'h0000_0000);
		`CHK("unmapped error", 1'b1, errv)
		// completion message held by the mask, then released
		apb(1'b1, 12'h0a4, 32'h0000_abcd);
		apb(1'b1, 12'h0a8, 32'h1000_0007);
		apb(1'b1, 12'h0ac, 32'h0000_0002);
		apb(1'b1, 12'h0c8, 32'h0000_0003);
		@(posedge clk);
		wait_done <= 1'b1;
		@(posedge clk);
		wait_done <= 1'b0;
		repeat (6) begin
			@(posedge clk);
			`CHK("held message", 1'b0, msg_valid)
		end
		rd_chk(12'h0a0, 32'hc000_0000);
		rd_chk(12'h09c, 32'h0000_0001);
		`CHK("irq on", 1'b1, irq)
		apb(1'b1, 12'h0c8, 32'h0000_0000);
		repeat (2) @(posedge clk);
		`CHK("irq masked", 1'b0, irq)
		apb(1'b1, 12'h0c8, 32'h0000_0003);
		apb(1'b1, 12'h0a0, 32'h0000_0000);
		n = 0;
		while (msg_valid !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		`CHK("message issued", 1'b1, msg_valid)
		if (n >= 20) begin
			tally_and_finish();
		end
		`CHK("message addr", 64'h0000_0002_1000_0004, msg.addr)
		`CHK("message data", 32'h0000_abcd, msg.data)
		msg_ready <= 1'b1;
		@(posedge clk);
		msg_ready <= 1'b0;
		@(posedge clk);
		`CHK("message accepted", 1'b0, msg_valid)
		rd_chk(12'h0a0, 32'h0000_0000);
		rd_chk(12'h0c0, 32'h0000_0003);
		apb(1'b1, 12'h0c4, 32'h0000_0003);
		apb(1'b1, 12'h09c, 32'h0000_0001);
		rd_chk(12'h0c0, 32'h0000_0000);
		rd_chk(12'h09c, 32'h0000_0000);
		`CHK("irq cleared", 1'b0, irq)
		// a completion seen while the clock enable is low leaves no trace
		@(posedge clk);
		ce <= 1'b0;
		wait_done <= 1'b1;
		@(posedge clk);
		wait_done <= 1'b0;
		ce <= 1'b1;
		rd_chk(12'h09c, 32'h0000_0000);
		rd_chk(12'h0a0, 32'h0000_0000);
		// all-ones writes under three capability sets: f, a and 0
		for (int p = 0; p < 3; p++) begin
			do_reset(caps[p]);
			for (int i = 0; i < 5; i++) begin
				rd_chk(offs[i], 32'h0000_0000);
				apb(1'b1, offs[i], 32'hffff_ffff);
			end
			for (int i = 0; i < 5; i++) begin
				rd_chk(offs[i], ones_exp(i, caps[p]));
			end
		end
		tally_and_finish();
	end
endmodule : ievm_regs_test
`default_nettype wire
